// File: core/irq_prio_pkg.sv
// Constants for the six interrupt priority control registers.
// Assumes a plain strobe register port, 16-bit data, word indices 1 to 6.
package irq_prio_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int PRIO_W = 3;
    localparam int NUM_REGS = 6;
    localparam int NUM_SRC = 22;
    // Register indices (word addresses on the register port)
    localparam logic [3:0] IRQ_PRIORITY_CTRL_1_IDX = 4'h1;
    localparam logic [3:0] IRQ_PRIORITY_CTRL_6_IDX = 4'h6;
    // Field low bit positions
    localparam int FLD3_LSB = 12;
    localparam int FLD2_LSB = 8;
    localparam int FLD1_LSB = 4;
    localparam int FLD0_LSB = 0;
    // Priority codes
    localparam logic [2:0] PRIO_RESET = 3'h4;
    localparam logic [2:0] PRIO_OFF = 3'h0;
    localparam logic [2:0] PRIO_LOWEST = 3'h1;
    localparam logic [2:0] PRIO_HIGHEST = 3'h7;
    // Implemented bits and reset values of each register, index 0 = register one
    localparam logic [15:0] MASK_FULL = 16'h7777;
    localparam logic [15:0] MASK_REG3 = 16'h0777;
    localparam logic [15:0] MASK_REG4 = 16'h7077;
    localparam logic [15:0] RESET_FULL = 16'h4444;
    localparam logic [15:0] RESET_REG3 = 16'h0444;
    localparam logic [15:0] RESET_REG4 = 16'h4044;
endpackage : irq_prio_pkg

// File: core/irq_priority_regs.sv
// Six priority control registers feeding interrupt arbitration.
// Assumes a same-clock register master: one-cycle strobes, read data next cycle.
//
// Notes on behaviour
// - Three-bit field, code 111 is level seven
// - Code 001 is level one, lowest enabled
// - Code 000 disables the source entirely
// - Unassigned bits ignore writes, read zero
// - Every field resets to code 100
// - Register one: timer2, outcmp2, incap2, dma0
// - Register two: uart1 rx, spi1 event/error, timer3
// - Register three: dma1, adc1, uart1 tx only
// - Register four: change notify, i2c1 master, slave
// - Register five: incap8, incap7, adc2, ext irq1
// - Register six: timer4, outcmp4, outcmp3, dma2
module irq_priority_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Per-source priorities toward arbitration
    output logic [2:0] timer2_prio,
    output logic [2:0] outcmp2_prio,
    output logic [2:0] incap2_prio,
    output logic [2:0] dma_ch0_done_prio,
    output logic [2:0] uart1_rx_prio,
    output logic [2:0] spi1_event_prio,
    output logic [2:0] spi1_error_prio,
    output logic [2:0] timer3_prio,
    output logic [2:0] dma_ch1_done_prio,
    output logic [2:0] adc1_done_prio,
    output logic [2:0] uart1_tx_prio,
    output logic [2:0] change_notify_prio,
    output logic [2:0] i2c1_master_prio,
    output logic [2:0] i2c1_slave_prio,
    output logic [2:0] incap8_prio,
    output logic [2:0] incap7_prio,
    output logic [2:0] adc2_done_prio,
    output logic [2:0] ext_irq1_prio,
    output logic [2:0] timer4_prio,
    output logic [2:0] outcmp4_prio,
    output logic [2:0] outcmp3_prio,
    output logic [2:0] dma_ch2_done_prio,
    // Source enabled (priority code not zero), one per source in field order
    output logic [21:0] src_enabled
);

    ////////////////////////////////////////////////////////////////////////////
    // Per-register masks and reset values

    function automatic logic [15:0] impl_mask(input int idx);
        case (idx)
            2: impl_mask = irq_prio_pkg::MASK_REG3;
            3: impl_mask = irq_prio_pkg::MASK_REG4;
            default: impl_mask = irq_prio_pkg::MASK_FULL;
        endcase
    endfunction : impl_mask

    function automatic logic [15:0] reset_val(input int idx);
        case (idx)
            2: reset_val = irq_prio_pkg::RESET_REG3;
            3: reset_val = irq_prio_pkg::RESET_REG4;
            default: reset_val = irq_prio_pkg::RESET_FULL;
        endcase
    endfunction : reset_val

    // Register index 1..6 maps to storage slot 0..5
    function automatic logic addr_hit(input logic [3:0] addr, input int idx);
        addr_hit = (addr == 4'(irq_prio_pkg::IRQ_PRIORITY_CTRL_1_IDX + 4'(idx)));
    endfunction : addr_hit

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    logic [15:0] prio_reg_ff [irq_prio_pkg::NUM_REGS];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prio_reg_ff[0] <= irq_prio_pkg::RESET_FULL;
            prio_reg_ff[1] <= irq_prio_pkg::RESET_FULL;
            prio_reg_ff[2] <= irq_prio_pkg::RESET_REG3;
            prio_reg_ff[3] <= irq_prio_pkg::RESET_REG4;
            prio_reg_ff[4] <= irq_prio_pkg::RESET_FULL;
            prio_reg_ff[5] <= irq_prio_pkg::RESET_FULL;
        end else begin
            for (int i = 0; i < irq_prio_pkg::NUM_REGS; i++) begin
                if (reg_wr && addr_hit(reg_addr, i)) begin
                    // Masking on write keeps unimplemented bits at zero forever
                    prio_reg_ff[i] <= reg_wdata & impl_mask(i);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path: unmapped indices and idle cycles return zero

    logic [15:0] nxt_rdata;

    always_comb begin
        nxt_rdata = '0;
        if (reg_rd) begin
            for (int i = 0; i < irq_prio_pkg::NUM_REGS; i++) begin
                if (addr_hit(reg_addr, i)) begin
                    nxt_rdata = prio_reg_ff[i];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Priority outputs, registered copies of the fields

    logic [2:0] nxt_prio [irq_prio_pkg::NUM_SRC];
    logic [2:0] prio_out_ff [irq_prio_pkg::NUM_SRC];

    function automatic logic [2:0] fld(input logic [15:0] r, input int lsb);
        fld = r[lsb +: irq_prio_pkg::PRIO_W];
    endfunction : fld

    always_comb begin
        nxt_prio[0] = fld(prio_reg_ff[0], irq_prio_pkg::FLD3_LSB);
        nxt_prio[1] = fld(prio_reg_ff[0], irq_prio_pkg::FLD2_LSB);
        nxt_prio[2] = fld(prio_reg_ff[0], irq_prio_pkg::FLD1_LSB);
        nxt_prio[3] = fld(prio_reg_ff[0], irq_prio_pkg::FLD0_LSB);
        nxt_prio[4] = fld(prio_reg_ff[1], irq_prio_pkg::FLD3_LSB);
        nxt_prio[5] = fld(prio_reg_ff[1], irq_prio_pkg::FLD2_LSB);
        nxt_prio[6] = fld(prio_reg_ff[1], irq_prio_pkg::FLD1_LSB);
        nxt_prio[7] = fld(prio_reg_ff[1], irq_prio_pkg::FLD0_LSB);
        nxt_prio[8] = fld(prio_reg_ff[2], irq_prio_pkg::FLD2_LSB);
        nxt_prio[9] = fld(prio_reg_ff[2], irq_prio_pkg::FLD1_LSB);
        nxt_prio[10] = fld(prio_reg_ff[2], irq_prio_pkg::FLD0_LSB);
        nxt_prio[11] = fld(prio_reg_ff[3], irq_prio_pkg::FLD3_LSB);
        nxt_prio[12] = fld(prio_reg_ff[3], irq_prio_pkg::FLD1_LSB);
        nxt_prio[13] = fld(prio_reg_ff[3], irq_prio_pkg::FLD0_LSB);
        nxt_prio[14] = fld(prio_reg_ff[4], irq_prio_pkg::FLD3_LSB);
        nxt_prio[15] = fld(prio_reg_ff[4], irq_prio_pkg::FLD2_LSB);
        nxt_prio[16] = fld(prio_reg_ff[4], irq_prio_pkg::FLD1_LSB);
        nxt_prio[17] = fld(prio_reg_ff[4], irq_prio_pkg::FLD0_LSB);
        nxt_prio[18] = fld(prio_reg_ff[5], irq_prio_pkg::FLD3_LSB);
        nxt_prio[19] = fld(prio_reg_ff[5], irq_prio_pkg::FLD2_LSB);
        nxt_prio[20] = fld(prio_reg_ff[5], irq_prio_pkg::FLD1_LSB);
        nxt_prio[21] = fld(prio_reg_ff[5], irq_prio_pkg::FLD0_LSB);
    end

    // Code equals level directly: 1 lowest, 7 highest, 0 off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int s = 0; s < irq_prio_pkg::NUM_SRC; s++) begin
                prio_out_ff[s] <= irq_prio_pkg::PRIO_RESET;
                src_enabled[s] <= 1'b1;
            end
        end else begin
            for (int s = 0; s < irq_prio_pkg::NUM_SRC; s++) begin
                prio_out_ff[s] <= nxt_prio[s];
                src_enabled[s] <= (nxt_prio[s] != irq_prio_pkg::PRIO_OFF);
            end
        end
    end

    assign timer2_prio = prio_out_ff[0];
    assign outcmp2_prio = prio_out_ff[1];
    assign incap2_prio = prio_out_ff[2];
    assign dma_ch0_done_prio = prio_out_ff[3];
    assign uart1_rx_prio = prio_out_ff[4];
    assign spi1_event_prio = prio_out_ff[5];
    assign spi1_error_prio = prio_out_ff[6];
    assign timer3_prio = prio_out_ff[7];
    assign dma_ch1_done_prio = prio_out_ff[8];
    assign adc1_done_prio = prio_out_ff[9];
    assign uart1_tx_prio = prio_out_ff[10];
    assign change_notify_prio = prio_out_ff[11];
    assign i2c1_master_prio = prio_out_ff[12];
    assign i2c1_slave_prio = prio_out_ff[13];
    assign incap8_prio = prio_out_ff[14];
    assign incap7_prio = prio_out_ff[15];
    assign adc2_done_prio = prio_out_ff[16];
    assign ext_irq1_prio = prio_out_ff[17];
    assign timer4_prio = prio_out_ff[18];
    assign outcmp4_prio = prio_out_ff[19];
    assign outcmp3_prio = prio_out_ff[20];
    assign dma_ch2_done_prio = prio_out_ff[21];

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    unimpl_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && addr_hit(reg_addr, 2) |=> reg_rdata[15:11] == 5'h00)
        else $error("register three upper bits not zero");

    unimpl_reg4_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && addr_hit(reg_addr, 3) |=> reg_rdata[11:7] == 5'h00 && reg_rdata[3] == 1'b0)
        else $error("register four gap bits not zero");

    write_effect_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 0) |=> prio_reg_ff[0] == ($past(reg_wdata) & irq_prio_pkg::MASK_FULL))
        else $error("register one write not stored");

    readback_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 5) ##1 reg_rd && addr_hit(reg_addr, 5) && !reg_wr
        |=> reg_rdata == ($past(reg_wdata, 2) & irq_prio_pkg::MASK_FULL))
        else $error("register six readback mismatch");

    // Unmapped indices must never leak a stored word
    unmapped_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && (reg_addr < irq_prio_pkg::IRQ_PRIORITY_CTRL_1_IDX || reg_addr > irq_prio_pkg::IRQ_PRIORITY_CTRL_6_IDX)
        |=> reg_rdata == '0)
        else $error("unmapped read not zero");

    idle_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == '0)
        else $error("read data outside its cycle");

    timer2_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 0) |=> ##1 timer2_prio == $past(reg_wdata[14:12], 2))
        else $error("timer2 priority not from bits 14-12");

    dma0_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 0) |=> ##1 dma_ch0_done_prio == $past(reg_wdata[2:0], 2))
        else $error("dma0 priority not from bits 2-0");

    outcmp2_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 0) |=> ##1 outcmp2_prio == $past(fld(reg_wdata, irq_prio_pkg::FLD2_LSB), 2))
        else $error("outcmp2 priority misplaced");

    incap2_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 0) |=> ##1 incap2_prio == $past(fld(reg_wdata, irq_prio_pkg::FLD1_LSB), 2))
        else $error("incap2 priority misplaced");

    spi1_event_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 1) |=> ##1 spi1_event_prio == $past(fld(reg_wdata, irq_prio_pkg::FLD2_LSB), 2))
        else $error("spi1 event priority misplaced");

    spi1_error_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 1) |=> ##1 spi1_error_prio == $past(fld(reg_wdata, irq_prio_pkg::FLD1_LSB), 2))
        else $error("spi1 error priority misplaced");

    timer3_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 1) |=> ##1 timer3_prio == $past(fld(reg_wdata, irq_prio_pkg::FLD0_LSB), 2))
        else $error("timer3 priority misplaced");

    adc1_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 2) |=> ##1 adc1_done_prio == $past(fld(reg_wdata, irq_prio_pkg::FLD1_LSB), 2))
        else $error("adc1 priority misplaced");

    uart1_tx_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 2) |=> ##1 uart1_tx_prio == $past(fld(reg_wdata, irq_prio_pkg::FLD0_LSB), 2))
        else $error("uart1 tx priority misplaced");

    i2c1_master_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 3) |=> ##1 i2c1_master_prio == $past(fld(reg_wdata, irq_prio_pkg::FLD1_LSB), 2))
        else $error("i2c1 master priority misplaced");

    incap8_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 4) |=> ##1 incap8_prio == $past(fld(reg_wdata, irq_prio_pkg::FLD3_LSB), 2))
        else $error("incap8 priority misplaced");

    ext_irq1_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 4) |=> ##1 ext_irq1_prio == $past(fld(reg_wdata, irq_prio_pkg::FLD0_LSB), 2))
        else $error("ext irq1 priority misplaced");

    timer4_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 5) |=> ##1 timer4_prio == $past(fld(reg_wdata, irq_prio_pkg::FLD3_LSB), 2))
        else $error("timer4 priority misplaced");

    uart1_rx_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 1) |=> ##1 uart1_rx_prio == $past(reg_wdata[14:12], 2))
        else $error("uart1 rx priority misplaced");

    dma1_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 2) |=> ##1 dma_ch1_done_prio == $past(reg_wdata[10:8], 2))
        else $error("dma1 priority misplaced");

    incap7_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 4) |=> ##1 incap7_prio == $past(reg_wdata[10:8], 2))
        else $error("incap7 priority misplaced");

    outcmp3_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 5) |=> ##1 outcmp3_prio == $past(reg_wdata[6:4], 2))
        else $error("outcmp3 priority misplaced");

    // Judged against the written word, not the output, so a stuck enable shows
    disable_src_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 0)
        |=> ##1 src_enabled[0] == ($past(fld(reg_wdata, irq_prio_pkg::FLD3_LSB), 2) != irq_prio_pkg::PRIO_OFF))
        else $error("source enable disagrees with code");

    highest_code_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 3) && reg_wdata[14:12] == 3'h7 |=> ##1 change_notify_prio == 3'h7)
        else $error("code 111 not level seven");

    lowest_code_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 3) && reg_wdata[2:0] == 3'h1 |=> ##1 i2c1_slave_prio == 3'h1 && src_enabled[13])
        else $error("code 001 not level one");

    linear_map_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && addr_hit(reg_addr, 4) && reg_wdata[6:4] == 3'h5 |=> ##1 adc2_done_prio == 3'h5)
        else $error("middle code not mapped linearly");

    reset_value_a: assert property (@(posedge clk)
        $rose(rst_n) |-> prio_reg_ff[3] == irq_prio_pkg::RESET_REG4 && ext_irq1_prio == irq_prio_pkg::PRIO_RESET)
        else $error("reset value not 100 pattern");

endmodule : irq_priority_regs

// File: testbench/irq_arb_model.sv
// Behavioural arbitration partner: highest level among pending sources.
// Assumes priorities arrive as 24 three-bit slots in register field order.
module irq_arb_model (
    // Priorities and pending flags
    input wire logic [71:0] slot_prio,
    input wire logic [23:0] pending,
    // Request toward the core
    output logic cpu_req,
    output logic [2:0] top_level
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        top_level = 3'h0;
        for (int s = 0; s < 24; s++) begin
            if (pending[s] && slot_prio[3*s +: 3] > top_level) begin
                top_level = slot_prio[3*s +: 3];
            end
        end
        // Level zero can never win, so a disabled source stays silent
        cpu_req = (top_level != 3'h0);
    end
endmodule : irq_arb_model

// File: testbench/irq_priority_regs_tb.sv
// Self-checking bench for the six priority control registers.
// Assumes the one-cycle read latency and two-edge output latency of the port.
module irq_priority_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, reg_wr, reg_rd;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic [23:0] pending;
    logic [15:0] shadow [1:6];
    wire logic [15:0] reg_rdata;
    wire logic [71:0] slot_prio;
    wire logic [21:0] src_enabled;
    wire logic cpu_req;
    wire logic [2:0] top_level;
    int n_errors = 0;
    int num_checks = 0;
    // Empty field slots of registers three and four
    assign slot_prio[26:24] = 3'h0;
    assign slot_prio[41:39] = 3'h0;
    irq_priority_regs uut (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_enabled(src_enabled),
        .timer2_prio(slot_prio[2:0]), .outcmp2_prio(slot_prio[5:3]), .incap2_prio(slot_prio[8:6]),
        .dma_ch0_done_prio(slot_prio[11:9]), .uart1_rx_prio(slot_prio[14:12]), .spi1_event_prio(slot_prio[17:15]),
        .spi1_error_prio(slot_prio[20:18]), .timer3_prio(slot_prio[23:21]), .dma_ch1_done_prio(slot_prio[29:27]),
        .adc1_done_prio(slot_prio[32:30]), .uart1_tx_prio(slot_prio[35:33]), .change_notify_prio(slot_prio[38:36]),
        .i2c1_master_prio(slot_prio[44:42]), .i2c1_slave_prio(slot_prio[47:45]), .incap8_prio(slot_prio[50:48]),
        .incap7_prio(slot_prio[53:51]), .adc2_done_prio(slot_prio[56:54]), .ext_irq1_prio(slot_prio[59:57]),
        .timer4_prio(slot_prio[62:60]), .outcmp4_prio(slot_prio[65:63]), .outcmp3_prio(slot_prio[68:66]),
        .dma_ch2_done_prio(slot_prio[71:69]));
    irq_arb_model arb (.slot_prio(slot_prio), .pending(pending), .cpu_req(cpu_req), .top_level(top_level));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] fmask(input int r);
        return (r == 3) ? 16'h0777 : (r == 4) ? 16'h7077 : 16'h7777;
    endfunction : fmask
    function automatic logic [71:0] exp_slots();
        logic [71:0] v;
        v = '0;
        for (int s = 0; s < 24; s++) begin
            v[3*s +: 3] = shadow[s/4 + 1][14 - 4*(s%4) -: 3];
        end
        return v;
    endfunction : exp_slots
    function automatic logic [21:0] exp_en();
        logic [21:0] e;
        int i;
        e = '0;
        i = 0;
        for (int s = 0; s < 24; s++) begin
            if (s != 8 && s != 13) begin
                e[i] = (shadow[s/4 + 1][14 - 4*(s%4) -: 3] != 3'h0);
                i++;
            end
        end
        return e;
    endfunction : exp_en
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_reg
    task automatic chk_out(input logic [71:0] got, input logic [71:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_out
    // Release happens in the next call, so no signal is driven twice per step
    task automatic bus_op(input logic wr, input logic rd, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= wr;
        reg_rd <= rd;
        reg_addr <= a;
        reg_wdata <= d;
    endtask : bus_op
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        bus_op(1'b1, 1'b0, a, d);
        if (a >= 4'h1 && a <= 4'h6) shadow[a] = d & fmask(a);
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        bus_op(1'b0, 1'b1, a, 16'h0000);
        bus_op(1'b0, 1'b0, 4'h0, 16'h0000);
        @(negedge clk);
        chk_reg(reg_rdata, exp, "read data");
        @(negedge clk);
        chk_reg(reg_rdata, 16'h0000, "read data after its cycle");
    endtask : rd_chk
    task automatic check_outs();
        bus_op(1'b0, 1'b0, 4'h0, 16'h0000);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk_out(slot_prio, exp_slots(), "field outputs");
        chk_out({50'h0, src_enabled}, {50'h0, exp_en()}, "source enables");
    endtask : check_outs
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_vals();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int r = 1; r <= 6; r++) shadow[r] = 16'h4444 & fmask(r);
        check_outs();
        for (int r = 1; r <= 6; r++) rd_chk(4'(r), 16'h4444 & fmask(r));
        $display("Test reset values finished");
    endtask : t_reset_vals
    task automatic t_codes();
        for (int c = 0; c < 8; c++) begin
            for (int r = 1; r <= 6; r++) wr_reg(4'(r), 16'h8888 | (16'h1111 * 16'(c)));
            check_outs();
            chk_out({68'h0, cpu_req, top_level}, {68'h0, c != 0, 3'(c)}, "arbiter request");
        end
        $display("Test priority codes finished");
    endtask : t_codes
    task automatic t_placement();
        for (int r = 1; r <= 6; r++) begin
            wr_reg(4'(r), {1'b1, 3'(r), 1'b0, 3'(r + 1), 1'b1, 3'(r + 2), 1'b0, 3'(r + 3)});
        end
        check_outs();
        for (int r = 1; r <= 6; r++) rd_chk(4'(r), shadow[r]);
        $display("Test field placement finished");
    endtask : t_placement
    task automatic t_unmapped();
        wr_reg(4'h0, 16'hFFFF);
        wr_reg(4'h7, 16'hFFFF);
        wr_reg(4'hF, 16'h0000);
        rd_chk(4'h0, 16'h0000);
        rd_chk(4'hF, 16'h0000);
        wr_reg(4'h4, 16'hFFFF);
        rd_chk(4'h4, 16'h7077);
        wr_reg(4'h6, 16'hA5C3);
        rd_chk(4'h6, 16'h2543);
        check_outs();
        $display("Test unmapped and back-to-back finished");
    endtask : t_unmapped
    task automatic give_verdict();
        $display("Checks made: %0d, mismatches: %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        pending = 24'hFFFFFF;
        t_reset_vals();
        t_codes();
        t_placement();
        t_unmapped();
        // Mid-run reset must restore every field
        t_reset_vals();
        give_verdict();
    end
endmodule : irq_priority_regs_tb
